// ### hdl/mtcm_cfg.svh
// Offsets, field positions, reset values and timing counts of the MAC control block
`ifndef MTCM_CFG_SVH
`define MTCM_CFG_SVH

// ----------------------------------------------------------------------------
// Indirect register offsets
// ----------------------------------------------------------------------------
`define MTCM_OFF_CTRL 16'h0000
`define MTCM_OFF_MGMT_ADDR 16'h0014
`define MTCM_OFF_MGMT_DATA 16'h0018

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define MTCM_CTRL_DEFER_BIT 5
`define MTCM_CTRL_TX_BIT 3
`define MTCM_CTRL_RX_BIT 2
`define MTCM_MA_PHY_LSB 11
`define MTCM_MA_REG_LSB 6
`define MTCM_MA_WRITE_BIT 1
`define MTCM_MA_BUSY_BIT 0
`define MTCM_MA_RESET 32'h00005ac0
`define MTCM_MD_RESET 16'h0000
`define MTCM_CTRL_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MTCM_CLK_NS 5
`define MTCM_BIT_NS_100 10
`define MTCM_BIT_NS_10 100
`define MTCM_BIT_CYC_100 ((`MTCM_BIT_NS_100 + `MTCM_CLK_NS - 1) / `MTCM_CLK_NS)
`define MTCM_BIT_CYC_10 ((`MTCM_BIT_NS_10 + `MTCM_CLK_NS - 1) / `MTCM_CLK_NS)
`define MTCM_DEFER_LIMIT_BITS 24288
`define MTCM_MDC_MIN_NS 400
`define MTCM_MDC_HALF_CYC ((`MTCM_MDC_MIN_NS / 2 + `MTCM_CLK_NS - 1) / `MTCM_CLK_NS)

// ----------------------------------------------------------------------------
// Management frame layout
// ----------------------------------------------------------------------------
`define MTCM_FRAME_BITS 64
`define MTCM_PREAMBLE 32'hffffffff
`define MTCM_START 2'h1
`define MTCM_OP_READ 2'h2
`define MTCM_OP_WRITE 2'h1
`define MTCM_TA_WRITE 2'h2
`define MTCM_TA_READ 2'h0
`define MTCM_TA_POS 6'h2e
`define MTCM_DATA_POS 6'h30
`define MTCM_LAST_POS 6'h3f

`endif

// ### hdl/mtcm_mdio_engine.sv
// Management frame serialiser: builds MDC and shifts one 64-bit frame per request
`timescale 1ns/1ps
`default_nettype none
`include "mtcm_cfg.svh"
module mtcm_mdio_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  mtcm_mdio_if.eng req,
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);

  mtcm_pkg::mtcm_eng_s q_reg;
  mtcm_pkg::mtcm_eng_s q_next;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    q_next.done = 1'b0;
    case (q_reg.state)
      mtcm_pkg::MTCM_ST_IDLE: begin
        q_next.mdc = 1'b0;
        q_next.oe = 1'b0;
        if (req.start) begin
          // Preamble, start, opcode, addresses, turnaround, data
          q_next.shift = {`MTCM_PREAMBLE, `MTCM_START,
                          req.wr ? `MTCM_OP_WRITE : `MTCM_OP_READ,
                          req.phy, req.regidx,
                          req.wr ? `MTCM_TA_WRITE : `MTCM_TA_READ,
                          req.wr ? req.wdata : 16'h0000};
          q_next.is_read = ~req.wr;
          q_next.pos = 6'h00;
          q_next.phase = 8'h00;
          q_next.oe = 1'b1;
          q_next.state = mtcm_pkg::MTCM_ST_RUN;
        end
      end
      mtcm_pkg::MTCM_ST_RUN: begin
        if (q_reg.phase == 8'(`MTCM_MDC_HALF_CYC - 1)) begin
          q_next.phase = 8'h00;
          q_next.mdc = ~q_reg.mdc;
          if (!q_reg.mdc) begin
            // PHY drives read data ahead of the rising edge
            if (q_reg.is_read && q_reg.pos >= `MTCM_DATA_POS) begin
              q_next.rdata = {q_reg.rdata[14:0], mdio_i};
            end
          end else if (q_reg.pos == `MTCM_LAST_POS) begin
            q_next.state = mtcm_pkg::MTCM_ST_IDLE;
            q_next.oe = 1'b0;
            q_next.done = 1'b1;
          end else begin
            q_next.pos = q_reg.pos + 6'h01;
            q_next.shift = {q_reg.shift[62:0], 1'b0};
            // Release the line for turnaround on reads
            q_next.oe = ~(q_reg.is_read && (q_reg.pos + 6'h01) >= `MTCM_TA_POS);
          end
        end else begin
          q_next.phase = q_reg.phase + 8'h01;
        end
      end
      default: begin
        q_next.state = mtcm_pkg::MTCM_ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  assign mdc = q_reg.mdc;
  assign mdio_o = q_reg.shift[63];
  assign mdio_oe = q_reg.oe;
  assign req.rdata = q_reg.rdata;
  assign req.done = q_reg.done;

endmodule
`default_nettype wire

// ### hdl/mtcm_mdio_if.sv
// Request and answer signals between the control block and the management engine
`timescale 1ns/1ps
`default_nettype none
interface mtcm_mdio_if;
  logic start;
  logic wr;
  logic [4:0] phy;
  logic [4:0] regidx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;

  modport ctrl (output start, output wr, output phy, output regidx, output wdata, input rdata, input done);
  modport eng (input start, input wr, input phy, input regidx, input wdata, output rdata, output done);
endinterface
`default_nettype wire

// ### hdl/mtcm_pkg.sv
// Types shared by the MAC control block and its management engine
`include "mtcm_cfg.svh"
package mtcm_pkg;

  typedef enum logic [0:0] {
    MTCM_ST_IDLE = 1'b0,
    MTCM_ST_RUN = 1'b1
  } mtcm_eng_state_e;

  typedef struct packed {
    mtcm_eng_state_e state;
    logic [63:0] shift;
    logic [5:0] pos;
    logic [7:0] phase;
    logic is_read;
    logic mdc;
    logic oe;
    logic [15:0] rdata;
    logic done;
  } mtcm_eng_s;

  typedef struct packed {
    logic defer_chk;
    logic tx_en;
    logic rx_en;
    logic [4:0] phy;
    logic [4:0] regidx;
    logic wr_sel;
    logic busy;
    logic start;
    logic [15:0] data;
    logic [31:0] rdata;
    logic rvalid;
    logic [4:0] pre;
    logic [14:0] defer;
    logic abort;
  } mtcm_top_s;

endpackage

// ### hdl/mtcm_top.sv
// MAC transmit deferral check, transmit/receive enables and management access registers
`timescale 1ns/1ps
`default_nettype none
`include "mtcm_cfg.svh"

// Notes on behaviour
// - With deferral checking on, a pending packet is abandoned once deferral exceeds the bit-time limit.
// - Deferral counting starts when a packet is ready but carrier sense holds it off.
// - A collision after transmission has begun resets the deferral counter.
// - With deferral checking off, deferral never ends in an abort.
// - Packets are transmitted only while the transmit enable bit is 1.
// - Incoming packets are accepted only while the receive enable bit is 1, otherwise dropped.
// - A five-bit field of the management address register selects the target PHY.
// - A five-bit field of the management address register selects the register inside the PHY.
// - The direction bit chooses a PHY register write when 1 and a read when 0.
// - The busy flag is 1 for the whole management instruction and clears when it completes.
// - The data register holds the word to write and receives the word read back.
module mtcm_top #(
  parameter int unsigned DEFER_LIMIT_BITS = `MTCM_DEFER_LIMIT_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic speed_100,
  input wire logic tx_pkt_ready,
  input wire logic tx_active,
  input wire logic crs,
  input wire logic col,
  output logic tx_enable,
  output logic tx_start_ok,
  output logic tx_defer_abort,
  input wire logic rx_pkt_valid,
  output logic rx_enable,
  output logic rx_pkt_accept,
  output logic rx_pkt_discard,
  output logic mgmt_busy,
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // Counter is 15 bits wide and must reach the limit plus one
  if (DEFER_LIMIT_BITS < 1 || DEFER_LIMIT_BITS > 32766) begin : g_bad_limit
    $error("DEFER_LIMIT_BITS out of range");
  end
  // Prescaler is 5 bits wide; the slow bit time must still fit
  if (`MTCM_BIT_CYC_10 < 1 || `MTCM_BIT_CYC_10 > 31) begin : g_bad_bit10
    $error("10 Mb/s bit time does not fit the prescaler");
  end
  if (`MTCM_BIT_CYC_100 < 1 || `MTCM_BIT_CYC_100 > 31) begin : g_bad_bit100
    $error("100 Mb/s bit time does not fit the prescaler");
  end
  // Engine phase counter is 8 bits wide
  if (`MTCM_MDC_HALF_CYC < 1 || `MTCM_MDC_HALF_CYC > 256) begin : g_bad_mdc
    $error("MDC half period does not fit the phase counter");
  end
  // The shifter holds exactly one frame
  if (`MTCM_FRAME_BITS != 64) begin : g_bad_frame
    $error("Management frame must be 64 bits");
  end
  // Field slices must stay inside the word
  if (`MTCM_MA_PHY_LSB > 27 || `MTCM_MA_REG_LSB > 27) begin : g_bad_fields
    $error("Management address field out of range");
  end
  // Distinct offsets keep the decode one-hot
  if (`MTCM_OFF_CTRL == `MTCM_OFF_MGMT_ADDR || `MTCM_OFF_CTRL == `MTCM_OFF_MGMT_DATA ||
      `MTCM_OFF_MGMT_ADDR == `MTCM_OFF_MGMT_DATA) begin : g_bad_offsets
    $error("Register offsets overlap");
  end

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  mtcm_pkg::mtcm_top_s q_reg;
  mtcm_pkg::mtcm_top_s q_next;
  mtcm_mdio_if mif ();

  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic [4:0] bit_cyc;
  logic bit_tick;
  logic deferring;
  logic defer_clear;
  logic defer_at_limit;
  logic defer_full;
  logic rd_ctrl;
  logic rd_maddr;
  logic rd_mdata;
  logic addr_wr_ok;
  logic data_wr_ok;

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  always_comb begin
    wr_ctrl = 1'b0;
    wr_addr = 1'b0;
    wr_data = 1'b0;
    if (reg_wr_en && reg_addr == `MTCM_OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr_en && reg_addr == `MTCM_OFF_MGMT_ADDR) begin
      wr_addr = 1'b1;
    end else if (reg_wr_en && reg_addr == `MTCM_OFF_MGMT_DATA) begin
      wr_data = 1'b1;
    end
  end

  // Read decode mirrors the write decode
  always_comb begin
    rd_ctrl = 1'b0;
    rd_maddr = 1'b0;
    rd_mdata = 1'b0;
    if (reg_rd_en && reg_addr == `MTCM_OFF_CTRL) begin
      rd_ctrl = 1'b1;
    end else if (reg_rd_en && reg_addr == `MTCM_OFF_MGMT_ADDR) begin
      rd_maddr = 1'b1;
    end else if (reg_rd_en && reg_addr == `MTCM_OFF_MGMT_DATA) begin
      rd_mdata = 1'b1;
    end
  end

  // Fields belong to the engine while busy, so such writes are dropped
  assign addr_wr_ok = wr_addr && !q_reg.busy;
  assign data_wr_ok = wr_data && !q_reg.busy;

  // --------------------------------------------------------------------------
  // Deferral timing
  // --------------------------------------------------------------------------
  // One tick per bit time at the current line rate
  assign bit_cyc = speed_100 ? 5'(`MTCM_BIT_CYC_100) : 5'(`MTCM_BIT_CYC_10);
  assign bit_tick = q_reg.pre == bit_cyc - 5'h01;

  // Carrier holds a ready packet off; once started, keep counting until it goes
  assign deferring = tx_pkt_ready && !tx_active && (crs || q_reg.defer != 15'h0000);
  assign defer_clear = !tx_pkt_ready || (tx_active && col);

  // Limit compare kept out of the next-state logic
  assign defer_at_limit = q_reg.defer >= 15'(DEFER_LIMIT_BITS);
  assign defer_full = q_reg.defer == 15'h7fff;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    q_next = q_reg;
    q_next.start = 1'b0;
    q_next.rvalid = 1'b0;
    q_next.abort = 1'b0;

    // Control register
    if (wr_ctrl) begin
      q_next.defer_chk = reg_wdata[`MTCM_CTRL_DEFER_BIT];
      q_next.tx_en = reg_wdata[`MTCM_CTRL_TX_BIT];
      q_next.rx_en = reg_wdata[`MTCM_CTRL_RX_BIT];
    end

    // Management address register; ignored while an instruction runs
    if (addr_wr_ok) begin
      q_next.phy = reg_wdata[`MTCM_MA_PHY_LSB +: 5];
      q_next.regidx = reg_wdata[`MTCM_MA_REG_LSB +: 5];
      q_next.wr_sel = reg_wdata[`MTCM_MA_WRITE_BIT];
      q_next.busy = 1'b1;
      q_next.start = 1'b1;
    end

    // Data register; held stable while the engine is shifting it out
    if (data_wr_ok) begin
      q_next.data = reg_wdata[15:0];
    end

    // Completion: busy drops in the same cycle the read word lands
    if (mif.done) begin
      q_next.busy = 1'b0;
      if (!q_reg.wr_sel) begin
        q_next.data = mif.rdata;
      end
    end

    // Read port; unmapped offsets answer zero
    if (reg_rd_en) begin
      q_next.rvalid = 1'b1;
      if (rd_ctrl) begin
        q_next.rdata = `MTCM_CTRL_RESET;
        q_next.rdata[`MTCM_CTRL_DEFER_BIT] = q_reg.defer_chk;
        q_next.rdata[`MTCM_CTRL_TX_BIT] = q_reg.tx_en;
        q_next.rdata[`MTCM_CTRL_RX_BIT] = q_reg.rx_en;
      end else if (rd_maddr) begin
        q_next.rdata = 32'h00000000;
        q_next.rdata[`MTCM_MA_PHY_LSB +: 5] = q_reg.phy;
        q_next.rdata[`MTCM_MA_REG_LSB +: 5] = q_reg.regidx;
        q_next.rdata[`MTCM_MA_WRITE_BIT] = q_reg.wr_sel;
        q_next.rdata[`MTCM_MA_BUSY_BIT] = q_reg.busy;
      end else if (rd_mdata) begin
        q_next.rdata = {16'h0000, q_reg.data};
      end else begin
        q_next.rdata = 32'h00000000;
      end
    end

    // Deferral counter in bit times
    if (defer_clear) begin
      q_next.pre = 5'h00;
      q_next.defer = 15'h0000;
    end else if (deferring) begin
      if (bit_tick) begin
        q_next.pre = 5'h00;
        // Abort on the bit that would pass the limit
        if (q_reg.defer_chk && defer_at_limit) begin
          q_next.defer = 15'h0000;
          q_next.abort = 1'b1;
        end else if (!defer_full) begin
          // Without the check the count saturates, never aborts
          q_next.defer = q_reg.defer + 15'h0001;
        end
      end else begin
        q_next.pre = q_reg.pre + 5'h01;
      end
    end else begin
      q_next.pre = 5'h00;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      q_reg <= '0;
      q_reg.phy <= 5'(`MTCM_MA_RESET >> `MTCM_MA_PHY_LSB);
      q_reg.regidx <= 5'(`MTCM_MA_RESET >> `MTCM_MA_REG_LSB);
      q_reg.data <= `MTCM_MD_RESET;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // --------------------------------------------------------------------------
  // Management engine
  // --------------------------------------------------------------------------
  assign mif.start = q_reg.start;
  assign mif.wr = q_reg.wr_sel;
  assign mif.phy = q_reg.phy;
  assign mif.regidx = q_reg.regidx;
  assign mif.wdata = q_reg.data;

  mtcm_mdio_engine u_engine (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .clk_en(clk_en),
    .req(mif.eng),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata = q_reg.rdata;
  assign reg_rd_valid = q_reg.rvalid;
  assign mgmt_busy = q_reg.busy;
  assign tx_enable = q_reg.tx_en;
  // Deferral aborts take priority over a start in the same cycle
  assign tx_start_ok = q_reg.tx_en && tx_pkt_ready && !crs && !q_reg.abort;
  assign tx_defer_abort = q_reg.abort;
  assign rx_enable = q_reg.rx_en;
  assign rx_pkt_accept = rx_pkt_valid && q_reg.rx_en;
  assign rx_pkt_discard = rx_pkt_valid && !q_reg.rx_en;

endmodule
`default_nettype wire

// ### verification/mtcm_phy_model.sv
// Behavioural management-bus PHY with 32 registers
`timescale 1ns/1ps
`default_nettype none
module mtcm_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h13
) (
  input wire logic mdc,
  input wire logic mdio_line,
  output logic phy_o,
  output logic phy_oe
);
  logic [15:0] mem [32];
  logic [31:0] sh = 32'h0;
  logic [5:0] n = 6'h1e;
  logic infr = 1'b0;
  logic rd_hit = 1'b0;
  logic wr_hit = 1'b0;
  logic [4:0] ridx = 5'h0;
  initial begin
    phy_o = 1'b0;
    phy_oe = 1'b0;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'hc3a0 + 16'(i);
    end
  end
  always @(posedge mdc) begin
    sh <= {sh[30:0], mdio_line};
    if (!infr) begin
      // Start pattern only after ones, so idle pull-up never fakes a frame
      if (sh == 32'hfffffffe && mdio_line) begin
        infr <= 1'b1;
        n <= 6'h0;
      end
    end else begin
      n <= n + 6'h1;
      if (n == 6'hb) begin
        ridx <= {sh[3:0], mdio_line};
        rd_hit <= sh[10:9] == 2'b10 && sh[8:4] == PHY_ADDR;
        wr_hit <= sh[10:9] == 2'b01 && sh[8:4] == PHY_ADDR;
      end
      if (n == 6'h1d) begin
        infr <= 1'b0;
        if (wr_hit) begin
          mem[ridx] <= {sh[14:0], mdio_line};
        end
      end
    end
  end
  // Second turnaround bit driven low, then data MSB first
  always @(negedge mdc) begin
    if (rd_hit && n >= 6'hd && n <= 6'h1d) begin
      phy_oe <= 1'b1;
      phy_o <= (n == 6'hd) ? 1'b0 : mem[ridx][4'(6'h1d - n)];
    end else begin
      phy_oe <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/mtcm_top_sva.sv
// Port-level assertions for the MAC control block
`timescale 1ns/1ps
`default_nettype none
module mtcm_top_sva #(
  parameter int unsigned DEFER_LIMIT_BITS = 24288
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic reg_rd_valid,
  input wire logic tx_pkt_ready,
  input wire logic tx_active,
  input wire logic crs,
  input wire logic tx_enable,
  input wire logic tx_start_ok,
  input wire logic tx_defer_abort,
  input wire logic rx_pkt_valid,
  input wire logic rx_enable,
  input wire logic rx_pkt_accept,
  input wire logic rx_pkt_discard,
  input wire logic mgmt_busy,
  input wire logic mdc,
  input wire logic mdio_oe
);
  logic [13:0] busy_cnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Busy length counter; frozen cycles are not counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_reg <= 14'h0;
    end else if (!mgmt_busy) begin
      busy_cnt_reg <= 14'h0;
    end else if (clk_en) begin
      busy_cnt_reg <= busy_cnt_reg + 14'h1;
    end
  end
  rx_accept_a: assert property (rx_pkt_accept == (rx_pkt_valid && rx_enable))
    else $error("accept differs from valid and enable");
  rx_drop_a: assert property (rx_pkt_discard == (rx_pkt_valid && !rx_enable))
    else $error("discard differs from valid and not enable");
  tx_gate_a: assert property (tx_start_ok == (tx_enable && tx_pkt_ready && !crs && !tx_defer_abort))
    else $error("start permission wrong");
  abort_once_a: assert property (tx_defer_abort |-> ($past(tx_pkt_ready) && !$past(tx_active)) ##1 !tx_defer_abort)
    else $error("abort without deferral or too long");
  busy_start_a: assert property (clk_en && reg_wr_en && reg_addr == 16'h0014 && !mgmt_busy |=> mgmt_busy)
    else $error("busy not set by address write");
  busy_len_a: assert property ($fell(mgmt_busy) |-> busy_cnt_reg >= 14'h13fb && busy_cnt_reg <= 14'h140a)
    else $error("busy length not one frame");
  busy_bound_a: assert property (mgmt_busy |-> busy_cnt_reg < 14'h1450)
    else $error("busy stuck");
  idle_quiet_a: assert property (!mgmt_busy && !$past(mgmt_busy) |-> !mdc && !mdio_oe)
    else $error("bus active while idle");
  mdc_half_a: assert property ($rose(mdc) |-> mdc[*8] ##32 mdc ##1 !mdc)
    else $error("clock half period not 40");
  rd_valid_a: assert property (clk_en && reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  frame_c: cover property ($fell(mgmt_busy));
  abort_c: cover property (tx_defer_abort);
  drop_c: cover property (rx_pkt_discard);
endmodule
bind mtcm_top mtcm_top_sva #(.DEFER_LIMIT_BITS(DEFER_LIMIT_BITS)) u_sva (
  .clk, .rst_n, .clk_en, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_rd_valid, .tx_pkt_ready,
  .tx_active, .crs, .tx_enable, .tx_start_ok, .tx_defer_abort, .rx_pkt_valid, .rx_enable,
  .rx_pkt_accept, .rx_pkt_discard, .mgmt_busy, .mdc, .mdio_oe
);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the MAC control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [4:0] PHY = 5'h13;
  logic clk, rst_n, clk_en, reg_wr_en, reg_rd_en, reg_rd_valid, speed_100, tx_pkt_ready, tx_active;
  logic crs, col, tx_enable, tx_start_ok, tx_defer_abort, rx_pkt_valid, rx_enable, rx_pkt_accept;
  logic rx_pkt_discard, mgmt_busy, mdc, mdio_i, mdio_o, mdio_oe, phy_o, phy_oe, mdio_line;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0] ph [3] = '{PHY, PHY, 5'h0b};
  logic [4:0] rg [3] = '{5'h07, 5'h1f, 5'h07};
  logic [15:0] ex [3] = '{16'h9a5e, 16'hc3bf, 16'hffff};
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  // Pull-up wins when nobody drives
  assign mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  assign mdio_i = mdio_line;
  mtcm_top #(.DEFER_LIMIT_BITS(4)) dut (.clk, .rst_n, .clk_en, .reg_addr, .reg_wr_en, .reg_rd_en,
    .reg_wdata, .reg_rdata, .reg_rd_valid, .speed_100, .tx_pkt_ready, .tx_active, .crs, .col,
    .tx_enable, .tx_start_ok, .tx_defer_abort, .rx_pkt_valid, .rx_enable, .rx_pkt_accept,
    .rx_pkt_discard, .mgmt_busy, .mdc, .mdio_i, .mdio_o, .mdio_oe);
  mtcm_phy_model #(.PHY_ADDR(PHY)) phy (.mdc, .mdio_line, .phy_o, .phy_oe);
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk({31'h0, reg_rd_valid}, 32'h1);
    d = reg_rdata;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Polls busy; a frame is about 5121 cycles, so 200 polls is ample
  task automatic wait_idle();
    logic [31:0] d;
    d = 32'h1;
    for (int i = 0; i < 200 && d[0] !== 1'b0; i++) begin
      repeat (40) @(negedge clk);
      rd(16'h0014, d);
    end
    chk({31'h0, d[0]}, 32'h0);
  endtask
  task automatic defer(input int maxc);
    n = 0;
    while (n < maxc && tx_defer_abort !== 1'b1) begin
      @(negedge clk);
      n++;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("BAD t=%0t timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, tx_pkt_ready, tx_active, crs, col, rx_pkt_valid} = 8'h0;
    {clk_en, speed_100, reg_addr, reg_wdata} = {2'h3, 48'h0};
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rdc(16'h0000, 32'h0);
    rdc(16'h0014, 32'h00005ac0);
    rdc(16'h0018, 32'h0);
    wr(16'h0020, 32'hffffffff);
    rdc(16'h0020, 32'h0);
    wr(16'h0000, 32'hffffffff);
    rdc(16'h0000, 32'h2c);
    for (int i = 0; i < 4; i++) begin
      wr(16'h0000, 32'(i) << 2);
      @(negedge clk);
      {tx_pkt_ready, rx_pkt_valid} = 2'h3;
      #1;
      chk({tx_enable, tx_start_ok, rx_enable, rx_pkt_accept, rx_pkt_discard}, {i[1], i[1], i[0], i[0], !i[0]});
    end
    // Deferral at 100 Mb/s: limit 4 bits is 10 clocks
    wr(16'h0000, 32'h2c);
    crs = 1'b1;
    defer(200);
    chk(32'(n >= 8 && n <= 12), 32'h1);
    @(negedge clk);
    tx_pkt_ready = 1'b0;
    @(negedge clk);
    tx_pkt_ready = 1'b1;
    repeat (6) @(negedge clk);
    {tx_active, col} = 2'h3;
    @(negedge clk);
    {tx_active, col} = 2'h0;
    defer(200);
    chk(32'(n >= 8 && n <= 12), 32'h1);
    tx_pkt_ready = 1'b0;
    wr(16'h0000, 32'h0c);
    tx_pkt_ready = 1'b1;
    defer(200);
    chk(32'(n), 32'hc8);
    crs = 1'b0;
    #1;
    chk({31'h0, tx_start_ok}, 32'h1);
    {tx_pkt_ready, speed_100} = 2'h0;
    wr(16'h0000, 32'h2c);
    {tx_pkt_ready, crs} = 2'h3;
    defer(200);
    chk(32'(n >= 80 && n <= 120), 32'h1);
    {tx_pkt_ready, crs} = 2'h0;
    // Frozen clock enable must drop a control write
    @(negedge clk);
    clk_en = 1'b0;
    wr(16'h0000, 32'h0);
    clk_en = 1'b1;
    rdc(16'h0000, 32'h2c);
    // Management write, with refused writes while busy
    wr(16'h0018, 32'h9a5e);
    wr(16'h0014, {16'h0, PHY, 5'h07, 6'h2});
    rdc(16'h0014, {16'h0, PHY, 5'h07, 6'h3});
    wr(16'h0018, 32'h1111);
    wr(16'h0014, 32'h0);
    wait_idle();
    rdc(16'h0014, {16'h0, PHY, 5'h07, 6'h2});
    rdc(16'h0018, 32'h9a5e);
    for (int k = 0; k < 3; k++) begin
      wr(16'h0014, {16'h0, ph[k], rg[k], 6'h0});
      chk({31'h0, mgmt_busy}, 32'h1);
      wait_idle();
      rdc(16'h0018, {16'h0, ex[k]});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
